/* File: include/crs_defines.vh */
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH
// ----------------------------------------
// condition code bit positions
// ----------------------------------------
`define CRS_CC_V 7
`define CRS_CC_ONE6 6
`define CRS_CC_ONE5 5
`define CRS_CC_H 4
`define CRS_CC_I 3
`define CRS_CC_N 2
`define CRS_CC_Z 1
`define CRS_CC_C 0
// ----------------------------------------
// reset values and fixed addresses
// ----------------------------------------
`define CRS_SP_RST 16'h00FF
`define CRS_SP_LOW_RST 8'hFF
`define CRS_CCR_RST 8'h68
`define CRS_CCR_ONES 8'h60
`define CRS_RVEC_HI 16'hFFFE
`define CRS_RVEC_LO 16'hFFFF
`define CRS_IVEC_TOP 16'hFFFC
`define CRS_STAB_CYC 13'h1000
`define CRS_STK_BYTES 3'h5
// ----------------------------------------
// software register indices
// ----------------------------------------
`define CRS_R_ACC 4'h0
`define CRS_R_IXL 4'h1
`define CRS_R_IXH 4'h2
`define CRS_R_SPL 4'h3
`define CRS_R_SPH 4'h4
`define CRS_R_PCL 4'h5
`define CRS_R_PCH 4'h6
`define CRS_R_CCR 4'h7
`define CRS_R_STAT 4'h8
// ----------------------------------------
// sequencer commands
// ----------------------------------------
`define CRS_C_NOP 5'h00
`define CRS_C_ADD 5'h01
`define CRS_C_ADC 5'h02
`define CRS_C_SUB 5'h03
`define CRS_C_SBC 5'h04
`define CRS_C_AND 5'h05
`define CRS_C_ORA 5'h06
`define CRS_C_EOR 5'h07
`define CRS_C_LDA 5'h08
`define CRS_C_ASL 5'h09
`define CRS_C_LSR 5'h0A
`define CRS_C_ROL 5'h0B
`define CRS_C_ROR 5'h0C
`define CRS_C_BTST 5'h0D
`define CRS_C_LDX 5'h0E
`define CRS_C_LDH 5'h0F
`define CRS_C_PUSH 5'h10
`define CRS_C_PULL 5'h11
`define CRS_C_SPRST 5'h12
`define CRS_C_CLRMSK 5'h13
`define CRS_C_SEI 5'h14
`define CRS_C_WAIT 5'h15
`define CRS_C_STOP 5'h16
`define CRS_C_JMP 5'h17
`define CRS_C_FETCH 5'h18
`define CRS_C_EAIX 5'h19
`define CRS_C_EASP 5'h1A
`endif

/* File: hdl/crs_regset.v */
`include "crs_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module crs_regset (
   input  wire        clk_i,
   input  wire        reset_n_i,
   // software register port
   input  wire [3:0]  sw_addr_i,
   input  wire [7:0]  sw_wdata_i,
   input  wire        sw_wr_i,
   input  wire        sw_rd_i,
   output reg  [7:0]  sw_rdata_o,
   // sequencer commands
   input  wire [4:0]  cmd_i,
   input  wire [7:0]  opd_i,
   input  wire [3:0]  sel_i,
   input  wire [15:0] off_i,
   output reg         cmd_ready_o,
   // maskable requests, bit 0 highest priority
   input  wire [7:0]  irq_i,
   output reg         irq_ack_o,
   output reg  [2:0]  irq_num_o,
   // memory side
   input  wire [7:0]  mem_rdata_i,
   output reg  [15:0] mem_addr_o,
   output reg         mem_rd_o,
   output reg         mem_wr_o,
   output reg  [7:0]  mem_wdata_o,
   // register views
   output reg  [7:0]  acc_o,
   output reg  [15:0] ix_o,
   output reg  [15:0] sp_o,
   output reg  [15:0] pc_o,
   output reg  [7:0]  ccr_o,
   output reg  [15:0] ea_o,
   output reg         core_clk_run_o
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam [8:0] S_VH   = 9'h001;
   localparam [8:0] S_VL   = 9'h002;
   localparam [8:0] S_VD   = 9'h004;
   localparam [8:0] S_VE   = 9'h008;
   localparam [8:0] S_RUN  = 9'h010;
   localparam [8:0] S_STK  = 9'h020;
   localparam [8:0] S_MASK = 9'h040;
   localparam [8:0] S_WAIT = 9'h080;
   localparam [8:0] S_STOP = 9'h100;

   reg [8:0]  state_q;
   reg [2:0]  stk_cnt_q;
   reg [15:0] vec_q;
   reg [7:0]  vhi_q;
   reg [12:0] stab_q;
   reg        stab_on_q;
   reg [7:0]  irq_m_q;
   reg [7:0]  irq_q;

   // ----------------------------------------
   // priority pick, lowest index wins
   // ----------------------------------------
   function [2:0] crs_pick;
      input [7:0] r;
      integer k;
      begin
         crs_pick = 3'h0;
         for (k = 7; k >= 0; k = k - 1) begin
            if (r[k]) begin
               crs_pick = k[2:0];
            end
         end
      end
   endfunction

   // requests come from other blocks' pins: two flops first
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         irq_m_q <= 8'h00;
         irq_q   <= 8'h00;
      end else begin
         irq_m_q <= irq_i;
         irq_q   <= irq_m_q;
      end
   end

   // ----------------------------------------
   // alu and flag update
   // ----------------------------------------
   reg [8:0] sum;
   reg [4:0] half;
   reg [7:0] res;
   reg [7:0] ccr_d;
   reg       cin;
   reg       wr_acc;
   reg       vf;
   reg       cf;

   // flags untouched unless the command names them
   always @* begin
      ccr_d  = ccr_o;
      cin    = ccr_o[`CRS_CC_C];
      sum    = 9'h000;
      half   = 5'h00;
      res    = acc_o;
      wr_acc = 1'b1;
      vf     = 1'b0;
      cf     = ccr_o[`CRS_CC_C];
      case (cmd_i)
         `CRS_C_ADD, `CRS_C_ADC: begin
            cin  = (cmd_i == `CRS_C_ADC) & ccr_o[`CRS_CC_C]; // plain add ignores carry in
            sum  = {1'b0, acc_o} + {1'b0, opd_i} + {8'h00, cin};
            half = {1'b0, acc_o[3:0]} + {1'b0, opd_i[3:0]} + {4'h0, cin};
            res  = sum[7:0];
            ccr_d[`CRS_CC_H] = half[4];
            vf = (acc_o[7] == opd_i[7]) && (res[7] != acc_o[7]);
            cf = sum[8];
         end
         `CRS_C_SUB, `CRS_C_SBC: begin
            cin = (cmd_i == `CRS_C_SBC) & ccr_o[`CRS_CC_C]; // plain subtract ignores borrow in
            sum = {1'b0, acc_o} - {1'b0, opd_i} - {8'h00, cin};
            res = sum[7:0];
            vf  = (acc_o[7] != opd_i[7]) && (res[7] != acc_o[7]);
            cf  = sum[8];
         end
         `CRS_C_AND: res = acc_o & opd_i;
         `CRS_C_ORA: res = acc_o | opd_i;
         `CRS_C_EOR: res = acc_o ^ opd_i;
         `CRS_C_LDA: res = opd_i;
         `CRS_C_ASL: begin
            res = {acc_o[6:0], 1'b0};
            cf  = acc_o[7];
         end
         `CRS_C_ROL: begin
            res = {acc_o[6:0], cin};
            cf  = acc_o[7];
         end
         `CRS_C_LSR: begin
            res = {1'b0, acc_o[7:1]};
            cf  = acc_o[0];
         end
         `CRS_C_ROR: begin
            res = {cin, acc_o[7:1]};
            cf  = acc_o[0];
         end
         default: begin
            wr_acc = 1'b0;
         end
      endcase
      if (wr_acc) begin
         if (cmd_i >= `CRS_C_ASL) begin
            vf = res[7] ^ cf; // shifts: n xor c
         end
         ccr_d[`CRS_CC_V] = vf;
         ccr_d[`CRS_CC_N] = res[7];
         ccr_d[`CRS_CC_Z] = (res == 8'h00);
         ccr_d[`CRS_CC_C] = cf;
      end
      // bit test copies the chosen operand bit into carry
      if (cmd_i == `CRS_C_BTST) begin
         ccr_d[`CRS_CC_C] = opd_i[sel_i[2:0]];
      end
   end

   // ----------------------------------------
   // stacked byte for interrupt entry
   // ----------------------------------------
   reg [7:0] stk_byte;

   // upper index byte is not in the frame
   always @* begin
      case (stk_cnt_q)
         3'h0: stk_byte = pc_o[7:0];
         3'h1: stk_byte = pc_o[15:8];
         3'h2: stk_byte = ix_o[7:0];
         3'h3: stk_byte = acc_o;
         default: stk_byte = ccr_o;
      endcase
   end

   // register picked by sel for push
   reg [7:0] sel_byte;
   always @* begin
      case (sel_i)
         `CRS_R_ACC: sel_byte = acc_o;
         `CRS_R_IXL: sel_byte = ix_o[7:0];
         `CRS_R_IXH: sel_byte = ix_o[15:8];
         `CRS_R_PCL: sel_byte = pc_o[7:0];
         `CRS_R_PCH: sel_byte = pc_o[15:8];
         `CRS_R_CCR: sel_byte = ccr_o;
         default:    sel_byte = 8'h00;
      endcase
   end

   wire [7:0] pend = irq_q;
   wire       take = (pend != 8'h00) && !ccr_o[`CRS_CC_I];

   // ----------------------------------------
   // main sequence and register file
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_q        <= S_VH;
         acc_o          <= 8'h00;
         ix_o           <= 16'h0000;
         sp_o           <= `CRS_SP_RST;
         pc_o           <= 16'h0000;
         ccr_o          <= `CRS_CCR_RST;
         ea_o           <= 16'h0000;
         stk_cnt_q      <= 3'h0;
         vec_q          <= `CRS_RVEC_HI;
         vhi_q          <= 8'h00;
         stab_q         <= 13'h0000;
         stab_on_q      <= 1'b0;
         mem_addr_o     <= 16'h0000;
         mem_rd_o       <= 1'b0;
         mem_wr_o       <= 1'b0;
         mem_wdata_o    <= 8'h00;
         irq_ack_o      <= 1'b0;
         irq_num_o      <= 3'h0;
         cmd_ready_o    <= 1'b0;
         core_clk_run_o <= 1'b0;
      end else begin
         mem_rd_o    <= 1'b0;
         mem_wr_o    <= 1'b0;
         irq_ack_o   <= 1'b0;
         cmd_ready_o <= 1'b0;
         // software pokes, core commands below take precedence
         if (sw_wr_i) begin
            case (sw_addr_i)
               `CRS_R_ACC: acc_o <= sw_wdata_i;
               `CRS_R_IXL: ix_o[7:0] <= sw_wdata_i;
               `CRS_R_IXH: ix_o[15:8] <= sw_wdata_i;
               `CRS_R_SPL: sp_o[7:0] <= sw_wdata_i;
               `CRS_R_SPH: sp_o[15:8] <= sw_wdata_i;
               `CRS_R_PCL: pc_o[7:0] <= sw_wdata_i;
               `CRS_R_PCH: pc_o[15:8] <= sw_wdata_i;
               `CRS_R_CCR: ccr_o <= sw_wdata_i | `CRS_CCR_ONES;
               default: ;
            endcase
         end
         case (state_q)
            // vector fetch: read high, read low, then load
            S_VH: begin
               mem_addr_o <= vec_q;
               mem_rd_o   <= 1'b1;
               state_q    <= S_VL;
            end
            S_VL: begin
               mem_addr_o <= vec_q + 16'h0001;
               mem_rd_o   <= 1'b1;
               state_q    <= S_VD;
            end
            S_VD: begin
               vhi_q   <= mem_rdata_i;
               state_q <= S_VE;
            end
            S_VE: begin
               pc_o           <= {vhi_q, mem_rdata_i};
               state_q        <= S_RUN;
               cmd_ready_o    <= 1'b1;
               core_clk_run_o <= 1'b1;
            end
            // five bytes pushed, one per clock
            S_STK: begin
               mem_addr_o  <= sp_o;
               mem_wdata_o <= stk_byte;
               mem_wr_o    <= 1'b1;
               sp_o        <= sp_o - 16'h0001;
               stk_cnt_q   <= stk_cnt_q + 3'h1;
               if (stk_cnt_q == `CRS_STK_BYTES - 3'h1) begin
                  state_q <= S_MASK;
               end
            end
            // mask after saving, before the vector reads
            S_MASK: begin
               ccr_o[`CRS_CC_I] <= 1'b1;
               state_q <= S_VH;
            end
            S_WAIT: begin
               if (take) begin
                  state_q <= S_RUN; // mask stays clear
               end
            end
            // clock held off until stabilisation elapses
            S_STOP: begin
               if (stab_on_q) begin
                  stab_q <= stab_q + 13'h0001;
                  if (stab_q == `CRS_STAB_CYC - 13'h0001) begin
                     stab_on_q <= 1'b0;
                     state_q   <= S_RUN;
                  end
               end else if (take) begin
                  stab_on_q <= 1'b1;
                  stab_q    <= 13'h0000;
               end
            end
            S_RUN: begin
               cmd_ready_o    <= 1'b1;
               core_clk_run_o <= 1'b1;
               if (cmd_i == `CRS_C_NOP && take) begin
                  // boundary: serve best request
                  irq_num_o      <= crs_pick(pend);
                  irq_ack_o      <= 1'b1;
                  vec_q          <= `CRS_IVEC_TOP - {12'h000, crs_pick(pend), 1'b0};
                  stk_cnt_q      <= 3'h0;
                  state_q        <= S_STK;
                  cmd_ready_o    <= 1'b0;
               end else begin
                  if (wr_acc) begin
                     acc_o <= res;
                  end
                  // only flag commands rewrite the flags, so a software poke survives
                  if (wr_acc || cmd_i == `CRS_C_BTST) begin
                     ccr_o <= ccr_d;
                  end
                  case (cmd_i)
                     `CRS_C_LDX: ix_o[7:0] <= opd_i;
                     `CRS_C_LDH: ix_o[15:8] <= opd_i;
                     `CRS_C_PUSH: begin
                        mem_addr_o  <= sp_o;
                        mem_wdata_o <= sel_byte;
                        mem_wr_o    <= 1'b1;
                        sp_o        <= sp_o - 16'h0001;
                     end
                     `CRS_C_PULL: begin
                        sp_o <= sp_o + 16'h0001;
                        case (sel_i)
                           `CRS_R_ACC: acc_o <= opd_i;
                           `CRS_R_IXL: ix_o[7:0] <= opd_i;
                           `CRS_R_IXH: ix_o[15:8] <= opd_i;
                           `CRS_R_PCL: pc_o[7:0] <= opd_i;
                           `CRS_R_PCH: pc_o[15:8] <= opd_i;
                           `CRS_R_CCR: ccr_o <= opd_i | `CRS_CCR_ONES;
                           default: ;
                        endcase
                     end
                     `CRS_C_SPRST: sp_o[7:0] <= `CRS_SP_LOW_RST;
                     `CRS_C_CLRMSK: ccr_o[`CRS_CC_I] <= 1'b0;
                     `CRS_C_SEI: ccr_o[`CRS_CC_I] <= 1'b1;
                     `CRS_C_WAIT: begin
                        ccr_o[`CRS_CC_I] <= 1'b0;
                        core_clk_run_o   <= 1'b0;
                        cmd_ready_o      <= 1'b0;
                        state_q          <= S_WAIT;
                     end
                     `CRS_C_STOP: begin
                        ccr_o[`CRS_CC_I] <= 1'b0;
                        core_clk_run_o   <= 1'b0;
                        cmd_ready_o      <= 1'b0;
                        state_q          <= S_STOP;
                     end
                     `CRS_C_JMP: pc_o <= off_i;
                     `CRS_C_FETCH: pc_o <= pc_o + 16'h0001;
                     `CRS_C_EAIX: ea_o <= ix_o + off_i;
                     `CRS_C_EASP: ea_o <= sp_o + off_i;
                     default: ;
                  endcase
               end
            end
            default: begin
               state_q <= S_VH;
            end
         endcase
      end
   end

   // ----------------------------------------
   // software read, data one cycle later
   // ----------------------------------------
   // unmapped indices read zero so probes are harmless
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         sw_rdata_o <= 8'h00;
      end else if (sw_rd_i) begin
         case (sw_addr_i)
            `CRS_R_ACC:  sw_rdata_o <= acc_o;
            `CRS_R_IXL:  sw_rdata_o <= ix_o[7:0];
            `CRS_R_IXH:  sw_rdata_o <= ix_o[15:8];
            `CRS_R_SPL:  sw_rdata_o <= sp_o[7:0];
            `CRS_R_SPH:  sw_rdata_o <= sp_o[15:8];
            `CRS_R_PCL:  sw_rdata_o <= pc_o[7:0];
            `CRS_R_PCH:  sw_rdata_o <= pc_o[15:8];
            `CRS_R_CCR:  sw_rdata_o <= ccr_o | `CRS_CCR_ONES;
            `CRS_R_STAT: sw_rdata_o <= {stab_on_q, state_q[8:7], state_q[4], 1'b0, irq_num_o};
            default:     sw_rdata_o <= 8'h00;
         endcase
      end else begin
         sw_rdata_o <= 8'h00;
      end
   end

endmodule
`default_nettype wire

/* File: dv/crs_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// program/data memory seen by the core
// ----------------------------------------
module crs_mem_model #(
   parameter logic [15:0] RVEC = 16'h1234,
   parameter logic [15:0] IV0  = 16'h2000,
   parameter logic [15:0] IV1  = 16'h2100
) (
   input  wire logic        clk_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic [7:0]  wdata_i,
   output var  logic [7:0]  rdata_o
);
   logic [7:0] mem [0:65535];
   // vectors, high byte first
   initial begin
      mem[16'hFFFE] = RVEC[15:8];
      mem[16'hFFFF] = RVEC[7:0];
      mem[16'hFFFC] = IV0[15:8];
      mem[16'hFFFD] = IV0[7:0];
      mem[16'hFFFA] = IV1[15:8];
      mem[16'hFFFB] = IV1[7:0];
      rdata_o = 8'h00;
   end
   // idle bus shows the inverse, so no stale byte is mistaken for data
   always @(posedge clk_i) begin
      if (wr_i)
         mem[addr_i] <= wdata_i;
      rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
   end
endmodule
`default_nettype wire

/* File: dv/crs_regset_asserts.sv */
`include "crs_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module crs_regset_asserts (
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   input wire logic [3:0]  sw_addr_i,
   input wire logic        sw_rd_i,
   input wire logic [7:0]  sw_rdata_o,
   input wire logic [4:0]  cmd_i,
   input wire logic [15:0] off_i,
   input wire logic        cmd_ready_o,
   input wire logic        irq_ack_o,
   input wire logic        mem_wr_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic [15:0] ix_o,
   input wire logic [15:0] sp_o,
   input wire logic [15:0] pc_o,
   input wire logic [7:0]  ccr_o,
   input wire logic [15:0] ea_o,
   input wire logic        core_clk_run_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // ----------------------------------------
   // register behaviour
   // ----------------------------------------
   a_reset_vals: assert property ($rose(reset_n_i) |-> sp_o == `CRS_SP_RST && ccr_o == `CRS_CCR_RST)
      else $error("reset values wrong");
   a_ccr_ones: assert property (ccr_o[6:5] == 2'b11)
      else $error("ccr bits 6 5 not one");
   a_ccr_read: assert property (sw_rd_i && sw_addr_i == `CRS_R_CCR |=> sw_rdata_o == ($past(ccr_o) | 8'h60))
      else $error("ccr read wrong");
   a_sp_low_set: assert property (cmd_ready_o && cmd_i == `CRS_C_SPRST |=> sp_o == ($past(sp_o) | 16'h00FF))
      else $error("stack reset wrong");
   a_push_dec: assert property (cmd_ready_o && cmd_i == `CRS_C_PUSH
      |=> mem_wr_o && mem_addr_o == $past(sp_o) && sp_o == $past(sp_o) - 16'h0001)
      else $error("push wrong");
   a_pull_inc: assert property (cmd_ready_o && cmd_i == `CRS_C_PULL |=> sp_o == $past(sp_o) + 16'h0001)
      else $error("pull wrong");
   a_jump_load: assert property (cmd_ready_o && cmd_i == `CRS_C_JMP |=> pc_o == $past(off_i))
      else $error("jump wrong");
   a_fetch_step: assert property (cmd_ready_o && cmd_i == `CRS_C_FETCH |=> pc_o == $past(pc_o) + 16'h0001)
      else $error("fetch wrong");
   a_index_ea: assert property (cmd_ready_o && cmd_i == `CRS_C_EAIX |=> ea_o == $past(ix_o) + $past(off_i))
      else $error("index address wrong");
   a_stack_ea: assert property (cmd_ready_o && cmd_i == `CRS_C_EASP |=> ea_o == $past(sp_o) + $past(off_i))
      else $error("stack address wrong");
   // ----------------------------------------
   // mask and low power
   // ----------------------------------------
   a_wait_mask: assert property (cmd_ready_o && cmd_i == `CRS_C_WAIT
      |=> !ccr_o[3] && !core_clk_run_o && !cmd_ready_o)
      else $error("wait wrong");
   a_masked_irq: assert property (cmd_ready_o && cmd_i == `CRS_C_NOP && ccr_o[3] |=> !irq_ack_o)
      else $error("masked request taken");
   a_entry_mask: assert property (irq_ack_o |-> ##[6:40] (cmd_ready_o && ccr_o[3]))
      else $error("entry mask not set");
   c_irq: cover property (irq_ack_o);
   c_wait: cover property (cmd_ready_o && cmd_i == `CRS_C_WAIT);
   c_push: cover property (cmd_ready_o && cmd_i == `CRS_C_PUSH);
endmodule
bind crs_regset crs_regset_asserts u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .sw_addr_i(sw_addr_i),
   .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o), .cmd_i(cmd_i), .off_i(off_i), .cmd_ready_o(cmd_ready_o),
   .irq_ack_o(irq_ack_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .ix_o(ix_o), .sp_o(sp_o),
   .pc_o(pc_o), .ccr_o(ccr_o), .ea_o(ea_o), .core_clk_run_o(core_clk_run_o));
`default_nettype wire

/* File: dv/cpu_register_set_and_flags_tb.sv */
`include "crs_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module cpu_register_set_and_flags_tb;
   logic        clk_i      = 1'b0;
   logic        reset_n_i  = 1'b0;
   logic [3:0]  sw_addr_i  = 4'h0;
   logic [7:0]  sw_wdata_i = 8'h00;
   logic        sw_wr_i    = 1'b0;
   logic        sw_rd_i    = 1'b0;
   logic [4:0]  cmd_i      = 5'h00;
   logic [7:0]  opd_i      = 8'h00;
   logic [3:0]  sel_i      = 4'h0;
   logic [15:0] off_i      = 16'h0000;
   logic [7:0]  irq_i      = 8'h00;
   wire  [7:0]  sw_rdata_o, mem_rdata_i, mem_wdata_o, acc_o, ccr_o;
   wire  [15:0] mem_addr_o, ix_o, sp_o, pc_o, ea_o;
   wire  [2:0]  irq_num_o;
   wire         cmd_ready_o, irq_ack_o, mem_rd_o, mem_wr_o, core_clk_run_o;
   int          err_count  = 0;
   int          compares   = 0;
   int          acks       = 0;
   logic [2:0]  num_q      = 3'h0;

   crs_regset DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i),
      .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o), .cmd_i(cmd_i), .opd_i(opd_i),
      .sel_i(sel_i), .off_i(off_i), .cmd_ready_o(cmd_ready_o), .irq_i(irq_i), .irq_ack_o(irq_ack_o),
      .irq_num_o(irq_num_o), .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
      .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .acc_o(acc_o), .ix_o(ix_o), .sp_o(sp_o), .pc_o(pc_o),
      .ccr_o(ccr_o), .ea_o(ea_o), .core_clk_run_o(core_clk_run_o));
   crs_mem_model u_mem (.clk_i(clk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
      .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

   always #10 clk_i = ~clk_i;
   // acknowledge is a one-cycle pulse, so count it here rather than poll
   always @(posedge clk_i) begin
      if (irq_ack_o === 1'b1) begin
         acks <= acks + 1;
         num_q <= irq_num_o;
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task chk(input logic [15:0] a, input logic [15:0] e);
      compares++;
      if (a !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sw_wr_i <= 1'b1;
      sw_addr_i <= a;
      sw_wdata_i <= d;
      @(posedge clk_i);
      sw_wr_i <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_i);
      sw_rd_i <= 1'b1;
      sw_addr_i <= a;
      @(posedge clk_i);
      sw_rd_i <= 1'b0;
      #1;
      chk(sw_rdata_o, e);
   endtask
   task op(input logic [4:0] c, input logic [7:0] o, input logic [3:0] s, input logic [15:0] f);
      @(posedge clk_i);
      cmd_i <= c;
      opd_i <= o;
      sel_i <= s;
      off_i <= f;
      @(posedge clk_i);
      cmd_i <= `CRS_C_NOP;
      #1;
   endtask
   task wt_rdy(input int n);
      for (int i = 0; i < n && cmd_ready_o !== 1'b1; i++) cyc(1);
      chk(cmd_ready_o, 1'b1);
   endtask
   task wt_ack(input int n);
      int a0;
      a0 = acks;
      for (int i = 0; i < n && acks == a0; i++) cyc(1);
      chk(16'(acks), 16'(a0 + 1));
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      cyc(8);
      chk(sp_o, `CRS_SP_RST);
      chk(ccr_o, `CRS_CCR_RST);
      @(posedge clk_i);
      reset_n_i <= 1'b1;
      wt_rdy(20);
      chk(pc_o, 16'h1234);
      chk(sp_o, `CRS_SP_RST);
   endtask
   task t_regs;
      wr(`CRS_R_ACC, 8'h5A);
      rd(`CRS_R_ACC, 8'h5A);
      op(`CRS_C_LDH, 8'hAB, 4'h0, 16'h0000);
      op(`CRS_C_LDX, 8'hCD, 4'h0, 16'h0000);
      chk(ix_o, 16'hABCD);
      wr(`CRS_R_IXH, 8'h12);
      wr(`CRS_R_IXL, 8'h34);
      cyc(1);
      chk(ix_o, 16'h1234);
      wr(`CRS_R_CCR, 8'h00);
      rd(`CRS_R_CCR, 8'h60);
      rd(4'hC, 8'h00);
   endtask
   task alu(input logic [4:0] c, input logic [7:0] a, o, cin, ae, ce, input logic [3:0] s);
      wr(`CRS_R_ACC, a);
      wr(`CRS_R_CCR, cin);
      op(c, o, s, 16'h0000);
      chk(acc_o, ae);
      chk(ccr_o, ce);
   endtask
   task t_alu;
      alu(`CRS_C_ADD, 8'h7F, 8'h01, 8'h60, 8'h80, 8'hF4, 4'h0);
      alu(`CRS_C_ADD, 8'hFF, 8'h01, 8'h60, 8'h00, 8'h73, 4'h0);
      alu(`CRS_C_ADC, 8'h08, 8'h07, 8'h61, 8'h10, 8'h70, 4'h0);
      alu(`CRS_C_SUB, 8'h00, 8'h01, 8'h60, 8'hFF, 8'h65, 4'h0);
      alu(`CRS_C_AND, 8'hF0, 8'h0F, 8'h61, 8'h00, 8'h63, 4'h0);
      alu(`CRS_C_LDA, 8'h00, 8'h80, 8'hE0, 8'h80, 8'h64, 4'h0);
      alu(`CRS_C_ASL, 8'h81, 8'h00, 8'h60, 8'h02, 8'hE1, 4'h0);
      alu(`CRS_C_BTST, 8'h11, 8'h08, 8'h60, 8'h11, 8'h61, 4'h3);
      alu(`CRS_C_SBC, 8'h10, 8'h01, 8'h61, 8'h0E, 8'h60, 4'h0);
      alu(`CRS_C_ORA, 8'h0F, 8'hF0, 8'h62, 8'hFF, 8'h64, 4'h0);
      alu(`CRS_C_EOR, 8'h55, 8'h55, 8'h64, 8'h00, 8'h62, 4'h0);
      alu(`CRS_C_LSR, 8'h01, 8'h00, 8'h60, 8'h00, 8'hE3, 4'h0);
      alu(`CRS_C_ROL, 8'h80, 8'h00, 8'h61, 8'h01, 8'hE1, 4'h0);
      alu(`CRS_C_ROR, 8'h01, 8'h00, 8'h61, 8'h80, 8'h65, 4'h0);
      alu(`CRS_C_SPRST, 8'h22, 8'h00, 8'h67, 8'h22, 8'h67, 4'h0);
   endtask
   task t_stack;
      wr(`CRS_R_ACC, 8'hA5);
      op(`CRS_C_PUSH, 8'h00, `CRS_R_ACC, 16'h0000);
      chk(sp_o, 16'h00FE);
      cyc(2);
      chk(u_mem.mem[16'h00FF], 8'hA5);
      op(`CRS_C_PULL, 8'h3C, `CRS_R_IXL, 16'h0000);
      chk(ix_o, 16'h123C);
      op(`CRS_C_EAIX, 8'h00, 4'h0, 16'h0010);
      chk(ea_o, 16'h124C);
      op(`CRS_C_EASP, 8'h00, 4'h0, 16'h0100);
      chk(ea_o, 16'h01FF);
      wr(`CRS_R_SPH, 8'h02);
      wr(`CRS_R_SPL, 8'h10);
      op(`CRS_C_SPRST, 8'h00, 4'h0, 16'h0000);
      chk(sp_o, 16'h02FF);
      wr(`CRS_R_SPH, 8'h00);
      op(`CRS_C_JMP, 8'h00, 4'h0, 16'h4000);
      op(`CRS_C_FETCH, 8'h00, 4'h0, 16'h0000);
      chk(pc_o, 16'h4001);
   endtask
   task t_irq;
      wr(`CRS_R_CCR, 8'h68);
      irq_i <= 8'h05;
      cyc(10);
      chk(16'(acks), 16'h0000);
      op(`CRS_C_CLRMSK, 8'h00, 4'h0, 16'h0000);
      wt_ack(10);
      chk(num_q, 3'h0);
      irq_i <= 8'h00;
      wt_rdy(60);
      chk(pc_o, 16'h2000);
      chk(ccr_o[3], 1'b1);
      chk(sp_o, 16'h00FA);
      chk(u_mem.mem[16'h00FF], 8'h01);
      chk(u_mem.mem[16'h00FD], 8'h3C);
      chk(u_mem.mem[16'h00FB], 8'h60);
      op(`CRS_C_PULL, 8'h60, `CRS_R_CCR, 16'h0000);
      chk(ccr_o, 8'h60);
   endtask
   task t_lowpow;
      op(`CRS_C_SEI, 8'h00, 4'h0, 16'h0000);
      op(`CRS_C_WAIT, 8'h00, 4'h0, 16'h0000);
      chk(ccr_o[3], 1'b0);
      irq_i <= 8'h02;
      wt_ack(20);
      chk(num_q, 3'h1);
      irq_i <= 8'h00;
      wt_rdy(60);
      chk(pc_o, 16'h2100);
      op(`CRS_C_WAIT, 8'h00, 4'h0, 16'h0000);
      t_reset();
      op(`CRS_C_STOP, 8'h00, 4'h0, 16'h0000);
      chk(ccr_o[3], 1'b0);
      irq_i <= 8'h01;
      cyc(4000);
      chk(core_clk_run_o, 1'b0);
      wt_ack(400);
      irq_i <= 8'h00;
      wt_rdy(60);
      chk(pc_o, 16'h2000);
   endtask
   task end_of_test;
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // watchdog sized well above the longest path, the stop recovery
   initial begin
      #400000;
      err_count++;
      end_of_test();
   end
   initial begin
      t_reset();
      t_regs();
      t_alu();
      t_stack();
      t_irq();
      t_lowpow();
      end_of_test();
   end
endmodule
`default_nettype wire
